// >>> hdl/fis_pkg.sv
// Purpose: Shared constants for the flag and interrupt sequencer
// Assumes: 8-bit data, 16-bit addresses, six maskable groups
// Notes: Group index 0 is the highest priority group
package fis_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int FIS_AW = 16;
  localparam int FIS_SPW = 6;
  localparam int FIS_NGRP = 6;

  // ****************************************************************
  // Flag register bit positions
  // ****************************************************************
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_I = 3;
  localparam int FLG_H = 4;
  localparam logic [2:0] FLG_UPPER_ONES = 3'b111;

  // ****************************************************************
  // Vectors
  // ****************************************************************
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_DECODER = 16'hFFFA;
  localparam logic [15:0] VEC_EXTPIN = 16'hFFF8;
  localparam logic [15:0] VEC_KEYWAKE = 16'hFFF6;
  localparam logic [15:0] VEC_TIMER = 16'hFFF4;
  localparam logic [15:0] VEC_SERIAL = 16'hFFF2;
  localparam logic [15:0] VEC_RTC = 16'hFFF0;

  // ****************************************************************
  // Stack window
  // ****************************************************************
  localparam logic [9:0] STK_BASE = 10'h003;
  localparam logic [5:0] STK_TOP = 6'h3F;
  localparam logic [2:0] STK_INT_BYTES = 3'h5;

  // ****************************************************************
  // ALU operations presented by the decoder
  // ****************************************************************
  typedef enum logic [3:0] {
    FIS_OP_NONE = 4'b0000,
    FIS_OP_ADD = 4'b0001,
    FIS_OP_ADC = 4'b0010,
    FIS_OP_LOGIC = 4'b0011,
    FIS_OP_LOAD = 4'b0100,
    FIS_OP_INCDEC = 4'b0101,
    FIS_OP_SHIFT = 4'b0110,
    FIS_OP_BITTEST = 4'b0111,
    FIS_OP_SUB = 4'b1000
  } fis_op_t;

endpackage : fis_pkg

// >>> hdl/fis_prio.sv
// Purpose: Fixed priority pick of pending maskable groups
// Assumes: Request bit 0 is the highest vector
// Notes: Pure combinational
`timescale 1ns/1ps
`default_nettype none
module fis_prio
  import fis_pkg::*;
(
  // Requests
  input wire logic [FIS_NGRP-1:0] req,
  // Result
  output logic any,
  output logic [15:0] vector
);

  always_comb
  begin
    any = |req;
    vector = VEC_RTC;
    if (req[0])
    begin
      vector = VEC_DECODER;
    end
    else if (req[1])
    begin
      vector = VEC_EXTPIN;
    end
    else if (req[2])
    begin
      vector = VEC_KEYWAKE;
    end
    else if (req[3])
    begin
      vector = VEC_TIMER;
    end
    else if (req[4])
    begin
      vector = VEC_SERIAL;
    end
  end

endmodule : fis_prio
`default_nettype wire

// >>> hdl/fis_seq.sv
// Purpose: Address counter, flags and interrupt entry/return sequencer
// Assumes: Decoder supplies results, carries and op strobes
// Notes: Memory bus is one byte per cycle, write or read
`timescale 1ns/1ps
`default_nettype none
module fis_seq
  import fis_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Instruction sequencer controls
  input wire logic fetch_step,
  input wire logic load_addr,
  input wire logic [15:0] load_value,
  input wire logic instr_done,
  input wire logic software_trap_op,
  input wire logic return_from_interrupt_op,
  input wire logic clear_mask_op,
  input wire logic wait_op,
  input wire logic set_mask_op,
  input wire logic call_push,
  input wire logic ret_pop,
  input wire logic reset_sp_op,
  // ALU results
  input wire logic [3:0] alu_op,
  input wire logic [7:0] alu_result,
  input wire logic alu_carry7,
  input wire logic alu_carry3,
  input wire logic alu_cbit,
  input wire logic [7:0] acc,
  input wire logic [7:0] index_reg,
  // Interrupt sources
  input wire logic [FIS_NGRP-1:0] irq_flag,
  input wire logic [FIS_NGRP-1:0] irq_enable,
  // Memory side
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  output logic mem_re,
  // Restored core registers
  output logic [7:0] restore_acc,
  output logic [7:0] restore_index,
  output logic restore_valid,
  // State
  output logic [15:0] instruction_address_counter,
  output logic [7:0] flag_register,
  output logic [5:0] stack_ptr,
  output logic busy
);

  // ****************************************************************
  // State machine
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_RESET_HI = 4'b0000,
    ST_RESET_LO = 4'b0001,
    ST_RUN = 4'b0010,
    ST_PUSH = 4'b0011,
    ST_VEC_HI = 4'b0100,
    ST_VEC_LO = 4'b0101,
    ST_POP = 4'b0110,
    ST_POP_LAST = 4'b0111
  } fis_state_t;

  fis_state_t state;
  fis_state_t next_state;
  logic [15:0] pc;
  logic [15:0] next_pc;
  logic [4:0] flags;
  logic [4:0] next_flags;
  logic mask_q;
  logic [3:0] arith_q;
  logic busy_q;
  logic next_busy;
  logic [5:0] sp;
  logic [5:0] next_sp;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [15:0] vec;
  logic [15:0] next_vec;
  logic [15:0] mem_addr_q;
  logic [15:0] next_mem_addr;
  logic [7:0] wdata_q;
  logic [7:0] next_wdata;
  logic we_q;
  logic next_we;
  logic re_q;
  logic next_re;
  logic [7:0] rst_acc;
  logic [7:0] next_rst_acc;
  logic [7:0] rst_idx;
  logic [7:0] next_rst_idx;
  logic rst_vld;
  logic next_rst_vld;
  logic trap_pend;
  logic next_trap_pend;
  logic [7:0] hold_pch;
  logic [7:0] next_hold_pch;
  logic prio_any;
  logic [15:0] prio_vec;
  logic [FIS_NGRP-1:0] live_req;

  // Stack address inside the window
  function automatic logic [15:0] stk_addr(input logic [5:0] p);
    stk_addr = {STK_BASE, p};
  endfunction : stk_addr

  // Flag byte with upper ones
  function automatic logic [7:0] flag_byte(input logic [4:0] f);
    flag_byte = {FLG_UPPER_ONES, f};
  endfunction : flag_byte

  assign live_req = irq_flag & irq_enable;
  // Mask and arithmetic flags live in separate registers
  assign flags = {arith_q[3], mask_q, arith_q[2:0]};
  assign next_busy = (next_state != ST_RUN);

  fis_prio u_prio
  (
    .req(live_req),
    .any(prio_any),
    .vector(prio_vec)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    next_state = state;
    next_pc = pc;
    next_flags = flags;
    next_sp = sp;
    next_cnt = cnt;
    next_vec = vec;
    next_mem_addr = mem_addr_q;
    next_wdata = wdata_q;
    next_we = 1'b0;
    next_re = 1'b0;
    next_rst_acc = rst_acc;
    next_rst_idx = rst_idx;
    next_rst_vld = 1'b0;
    next_trap_pend = trap_pend;
    next_hold_pch = hold_pch;
    unique case (state)
      ST_RESET_HI:
      begin
        next_flags[FLG_I] = 1'b1;
        next_mem_addr = VEC_RESET;
        next_re = 1'b1;
        next_state = ST_RESET_LO;
      end
      ST_RESET_LO:
      begin
        next_pc[15:8] = mem_rdata;
        next_mem_addr = VEC_RESET + 16'h0001;
        next_re = 1'b1;
        next_vec = VEC_RESET;
        next_state = ST_VEC_LO;
      end
      ST_RUN:
      begin
        if (fetch_step)
        begin
          next_pc = pc + 16'h0001;
        end
        if (load_addr)
        begin
          next_pc = load_value;
        end
        // Flag updates from the executing instruction
        unique case (alu_op)
          FIS_OP_ADD, FIS_OP_ADC:
          begin
            next_flags[FLG_H] = alu_carry3;
            next_flags[FLG_C] = alu_carry7;
          end
          FIS_OP_SUB, FIS_OP_LOGIC:
          begin
            next_flags[FLG_C] = alu_carry7;
          end
          FIS_OP_SHIFT, FIS_OP_BITTEST:
          begin
            next_flags[FLG_C] = alu_cbit;
          end
          default:
          begin
            next_flags[FLG_C] = flags[FLG_C];
          end
        endcase
        if (alu_op != FIS_OP_NONE && alu_op != FIS_OP_BITTEST)
        begin
          next_flags[FLG_N] = alu_result[7];
          next_flags[FLG_Z] = (alu_result == 8'h00);
        end
        if (clear_mask_op || wait_op)
        begin
          next_flags[FLG_I] = 1'b0;
        end
        if (set_mask_op)
        begin
          next_flags[FLG_I] = 1'b1;
        end
        if (reset_sp_op)
        begin
          next_sp = STK_TOP;
        end
        else if (call_push)
        begin
          next_sp = sp - 6'h02;
        end
        else if (ret_pop)
        begin
          next_sp = sp + 6'h02;
        end
        if (software_trap_op)
        begin
          next_trap_pend = 1'b1;
        end
        // Entry only at instruction boundary
        if (instr_done)
        begin
          if (return_from_interrupt_op)
          begin
            next_cnt = 3'h0;
            next_sp = sp + 6'h01;
            next_mem_addr = stk_addr(sp + 6'h01);
            next_re = 1'b1;
            next_state = ST_POP;
          end
          else if (software_trap_op || trap_pend ||
                   (prio_any && !flags[FLG_I]))
          begin
            next_cnt = 3'h0;
            next_state = ST_PUSH;
          end
        end
      end
      ST_PUSH:
      begin
        unique case (cnt)
          3'h0: next_wdata = next_pc[7:0];
          3'h1: next_wdata = pc[15:8];
          3'h2: next_wdata = index_reg;
          3'h3: next_wdata = acc;
          default: next_wdata = flag_byte(flags);
        endcase
        next_mem_addr = stk_addr(sp);
        next_we = 1'b1;
        next_sp = sp - 6'h01;
        next_cnt = cnt + 3'h1;
        if (cnt == STK_INT_BYTES - 3'h1)
        begin
          next_flags[FLG_I] = 1'b1;
          // Trap wins, else highest pending vector
          next_vec = (trap_pend || software_trap_op) ? VEC_TRAP : prio_vec;
          next_trap_pend = 1'b0;
          next_state = ST_VEC_HI;
        end
      end
      ST_VEC_HI:
      begin
        next_mem_addr = vec;
        next_re = 1'b1;
        next_state = ST_RESET_LO;
        next_hold_pch = 8'h00;
        if (vec != VEC_RESET)
        begin
          next_state = ST_VEC_LO;
        end
      end
      ST_VEC_LO:
      begin
        if (vec == VEC_RESET || mem_addr_q[0])
        begin
          next_pc[7:0] = mem_rdata;
          next_pc[15:8] = (vec == VEC_RESET) ? pc[15:8] : hold_pch;
          next_state = ST_RUN;
        end
        else
        begin
          next_hold_pch = mem_rdata;
          next_mem_addr = vec + 16'h0001;
          next_re = 1'b1;
        end
      end
      ST_POP:
      begin
        // reverse order: flags, acc, index, pc high, pc low
        unique case (cnt)
          3'h0: next_flags = mem_rdata[4:0];
          3'h1: next_rst_acc = mem_rdata;
          3'h2: next_rst_idx = mem_rdata;
          3'h3: next_pc[15:8] = mem_rdata;
          default: next_pc[7:0] = mem_rdata;
        endcase
        next_cnt = cnt + 3'h1;
        if (cnt == STK_INT_BYTES - 3'h1)
        begin
          next_rst_vld = 1'b1;
          next_state = ST_RUN;
        end
        else
        begin
          next_sp = sp + 6'h01;
          next_mem_addr = stk_addr(sp + 6'h01);
          next_re = 1'b1;
          next_state = (cnt == STK_INT_BYTES - 3'h2) ? ST_POP_LAST : ST_POP;
        end
      end
      ST_POP_LAST:
      begin
        next_pc[7:0] = mem_rdata;
        next_rst_vld = 1'b1;
        next_state = ST_RUN;
      end
      default:
      begin
        next_state = ST_RESET_HI;
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= ST_RESET_HI;
      pc <= 16'h0000;
      sp <= STK_TOP;
      cnt <= 3'h0;
      vec <= VEC_RESET;
      mem_addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      we_q <= 1'b0;
      re_q <= 1'b0;
      rst_acc <= 8'h00;
      rst_idx <= 8'h00;
      rst_vld <= 1'b0;
      trap_pend <= 1'b0;
      hold_pch <= 8'h00;
      mask_q <= 1'b1;
      busy_q <= 1'b1;
    end
    else if (clk_en)
    begin
      state <= next_state;
      pc <= next_pc;
      sp <= next_sp;
      cnt <= next_cnt;
      vec <= next_vec;
      mem_addr_q <= next_mem_addr;
      wdata_q <= next_wdata;
      we_q <= next_we;
      re_q <= next_re;
      rst_acc <= next_rst_acc;
      rst_idx <= next_rst_idx;
      rst_vld <= next_rst_vld;
      trap_pend <= next_trap_pend;
      hold_pch <= next_hold_pch;
      mask_q <= next_flags[FLG_I];
      busy_q <= next_busy;
    end
  end

  // Arithmetic flags keep their value through reset
  always_ff @(posedge ref_clk)
  begin
    if (clk_en && !reset)
    begin
      arith_q <= {next_flags[FLG_H], next_flags[FLG_N], next_flags[FLG_Z], next_flags[FLG_C]};
    end
  end

  assign mem_addr = mem_addr_q;
  assign mem_wdata = wdata_q;
  assign mem_we = we_q;
  assign mem_re = re_q;
  assign restore_acc = rst_acc;
  assign restore_index = rst_idx;
  assign restore_valid = rst_vld;
  assign instruction_address_counter = pc;
  assign flag_register = flag_byte(flags);
  assign stack_ptr = sp;
  assign busy = busy_q;

endmodule : fis_seq
`default_nettype wire

// >>> tb/fis_seq_props.sv
// Purpose: Port checks for fis_seq
// Assumes: One clock domain, reset active high
// Notes: Bound to every fis_seq instance
`timescale 1ns/1ps
`default_nettype none
module fis_seq_props
  import fis_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Inputs
  input wire logic clk_en,
  input wire logic fetch_step,
  input wire logic load_addr,
  input wire logic [15:0] load_value,
  input wire logic instr_done,
  input wire logic clear_mask_op,
  input wire logic set_mask_op,
  input wire logic [3:0] alu_op,
  input wire logic [7:0] alu_result,
  input wire logic alu_carry3,
  // Outputs
  input wire logic [15:0] mem_addr,
  input wire logic mem_we,
  input wire logic mem_re,
  input wire logic [15:0] instruction_address_counter,
  input wire logic [7:0] flag_register,
  input wire logic busy
);
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  logic run;
  logic [15:0] pc;
  assign run = !busy && clk_en && !instr_done;
  assign pc = instruction_address_counter;

  a_upper_ones: assert property (flag_register[7:5] == FLG_UPPER_ONES)
    else $error("flag upper bits not ones");
  a_pc_step: assert property (run && fetch_step && !load_addr |=> pc == $past(pc) + 16'h1)
    else $error("address counter did not step");
  a_pc_load: assert property (run && load_addr |=> pc == $past(load_value))
    else $error("address counter not loaded");
  a_mask_clear: assert property (run && clear_mask_op && !set_mask_op |=> !flag_register[FLG_I])
    else $error("mask not cleared");
  a_mask_reset: assert property ($past(reset) |-> flag_register[FLG_I])
    else $error("mask clear after reset");
  a_reset_vec: assert property ($past(reset) |-> ##[0:6] (mem_re && mem_addr == VEC_RESET))
    else $error("reset vector not read");
  a_stack_page: assert property (mem_we |-> mem_addr[15:6] == STK_BASE)
    else $error("write outside stack window");
  a_push_five: assert property ($rose(mem_we) |-> mem_we [*5] ##1 !mem_we)
    else $error("stacking not five bytes");
  a_mask_vector: assert property (mem_re && mem_addr[15:4] == 12'hFFF |-> flag_register[FLG_I])
    else $error("vector read with mask clear");
  a_half_carry: assert property (run && alu_op == FIS_OP_ADD |=> flag_register[FLG_H] == $past(alu_carry3))
    else $error("half carry wrong");
  a_load_flags: assert property (run && alu_op == FIS_OP_LOAD |=>
      flag_register[FLG_N] == ($past(alu_result) >= 8'h80) &&
      flag_register[FLG_Z] == ($past(alu_result) == 8'h00))
    else $error("load flags wrong");
  a_carry_keep: assert property (run && alu_op == FIS_OP_INCDEC |=> $stable(flag_register[FLG_C]))
    else $error("carry changed on step op");
endmodule : fis_seq_props
bind fis_seq fis_seq_props fis_seq_props_inst (.ref_clk, .reset, .clk_en, .fetch_step,
  .load_addr, .load_value, .instr_done, .clear_mask_op, .set_mask_op, .alu_op, .alu_result,
  .alu_carry3, .mem_addr, .mem_we, .mem_re, .instruction_address_counter, .flag_register,
  .busy);
`default_nettype wire

// >>> tb/fis_src_model.sv
// Purpose: Interrupt sources and memory beside fis_seq
// Assumes: Read data stands while the registered read strobe is high
// Notes: Idle read data toggles so stale bytes never match
`timescale 1ns/1ps
`default_nettype none
module fis_src_model
  import fis_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Source controls
  input wire logic [FIS_NGRP-1:0] set_f,
  input wire logic [FIS_NGRP-1:0] clr_f,
  input wire logic [FIS_NGRP-1:0] en_in,
  output logic [FIS_NGRP-1:0] irq_flag,
  output logic [FIS_NGRP-1:0] irq_enable,
  // Memory
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  input wire logic mem_re,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [256];
  logic [7:0] idle_q;
  initial
  begin
    irq_flag = '0;
    irq_enable = '0;
    idle_q = 8'h00;
  end
  always_comb
  begin
    if (!mem_re)
      mem_rdata = idle_q;
    else if (mem_addr[15:8] == 8'h00)
      mem_rdata = ram[mem_addr[7:0]];
    else
      mem_rdata = mem_addr[7:0] ^ 8'hA5;
  end
  // Flags hold until cleared by software
  always @(posedge ref_clk)
  begin
    irq_flag <= (irq_flag | set_f) & ~clr_f;
    irq_enable <= en_in;
    if (mem_we)
      ram[mem_addr[7:0]] <= mem_wdata;
    idle_q <= ~idle_q;
  end
endmodule : fis_src_model
`default_nettype wire

// >>> tb/fis_seq_tb.sv
// Purpose: Self-checking bench for fis_seq
// Assumes: Vector bytes come from fis_src_model
// Notes: Writes, resumes and restores are checked off queues
`timescale 1ns/1ps
`default_nettype none
module fis_seq_tb
  import fis_pkg::*;
;
  logic ref_clk, reset, clk_en, fetch_step, load_addr, instr_done, wait_op;
  logic software_trap_op, return_from_interrupt_op, clear_mask_op, set_mask_op;
  logic call_push, ret_pop, reset_sp_op, alu_carry7, alu_carry3, alu_cbit;
  logic restore_valid, mem_we, mem_re, busy, h, m, n, z, c, m_s;
  logic prev_busy = 1'b1;
  logic [3:0] alu_op;
  logic [7:0] alu_result, acc, index_reg, mem_rdata, mem_wdata, restore_acc, restore_index;
  logic [7:0] flag_register;
  logic [15:0] load_value, mem_addr, instruction_address_counter, pc, pc_s;
  logic [5:0] irq_flag, irq_enable, set_f, clr_f, en_in, sp, pend;
  logic [23:0] wq[$];
  logic [16:0] pq[$];
  logic [15:0] rq[$];
  int failures, checked, cyc, lo;

  fis_seq fis_seq_inst (.ref_clk, .reset, .clk_en, .fetch_step, .load_addr, .load_value,
    .instr_done, .software_trap_op, .return_from_interrupt_op, .clear_mask_op, .wait_op,
    .set_mask_op, .call_push, .ret_pop, .reset_sp_op, .alu_op, .alu_result, .alu_carry7,
    .alu_carry3, .alu_cbit, .acc, .index_reg, .irq_flag, .irq_enable, .mem_rdata, .mem_addr,
    .mem_wdata, .mem_we, .mem_re, .restore_acc, .restore_index, .restore_valid,
    .instruction_address_counter, .flag_register, .stack_ptr(), .busy);
  fis_src_model fis_src_model_inst (.ref_clk, .set_f, .clr_f, .en_in, .irq_flag,
    .irq_enable, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic compare(input string what, input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : compare

  task automatic stop_test();
    if (failures == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  // ****************************************
  // Result watcher
  // ****************************************
  always @(posedge ref_clk)
  begin
    cyc++;
    prev_busy <= busy;
    if (!reset && mem_we)
      compare("push", wq.size() ? wq.pop_front() : 'x, {mem_addr, mem_wdata});
    if (!reset && prev_busy && !busy)
      compare("resume", pq.size() ? pq.pop_front() : 'x,
        {flag_register[FLG_I], instruction_address_counter});
    if (!reset && restore_valid)
      compare("restore", rq.size() ? rq.pop_front() : 'x, {restore_acc, restore_index});
    if (cyc == 5000)
    begin
      failures++;
      stop_test();
    end
  end

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask : tick

  task automatic wait_run();
    int k;
    k = 0;
    tick();
    while (busy !== 1'b0 && k < 40)
    begin
      tick();
      k++;
    end
    if (k == 40)
      failures++;
  endtask : wait_run

  function automatic logic [15:0] vval(input logic [15:0] v);
    return {v[7:0] ^ 8'hA5, (v[7:0] + 8'h01) ^ 8'hA5};
  endfunction : vval

  task automatic reset_run(input int cycles);
    reset = 1'b1;
    repeat (cycles) tick();
    pq.push_back({1'b1, vval(VEC_RESET)});
    {pc, m, sp} = {vval(VEC_RESET), 1'b1, STK_TOP};
    reset = 1'b0;
    wait_run();
  endtask : reset_run

  task automatic alu(input fis_op_t op);
    alu_op = op;
    {alu_result, alu_carry7, alu_carry3, alu_cbit} = 11'($urandom);
    if (op == FIS_OP_ADD)
      {h, c} = {alu_carry3, alu_carry7};
    {n, z} = {alu_result[7], alu_result == 8'h00};
    tick();
    alu_op = FIS_OP_NONE;
  endtask : alu

  task automatic move();
    fetch_step = 1'b1;
    tick();
    pc++;
    load_value = 16'($urandom);
    load_addr = 1'b1;
    tick();
    {fetch_step, load_addr} = '0;
    pc = load_value;
  endtask : move

  task automatic enter(input logic [15:0] v, input logic trap);
    logic [7:0] d[5];
    acc = 8'($urandom);
    index_reg = 8'($urandom);
    d = '{pc[7:0], pc[15:8], index_reg, acc, {3'b111, h, m, n, z, c}};
    for (int k = 0; k < 5; k++)
      wq.push_back({STK_BASE, sp - 6'(k), d[k]});
    pq.push_back({1'b1, vval(v)});
    {pc_s, m_s} = {pc, m};
    software_trap_op = trap;
    instr_done = 1'b1;
    tick();
    {software_trap_op, instr_done} = '0;
    wait_run();
    {pc, m, sp} = {vval(v), 1'b1, sp - 6'h5};
  endtask : enter

  task automatic leave();
    pq.push_back({m_s, pc_s});
    rq.push_back({acc, index_reg});
    return_from_interrupt_op = 1'b1;
    instr_done = 1'b1;
    tick();
    {return_from_interrupt_op, instr_done} = '0;
    wait_run();
    {pc, m, sp} = {pc_s, m_s, sp + 6'h5};
  endtask : leave

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    {reset, clk_en, fetch_step, load_addr, instr_done, wait_op, software_trap_op} = 7'h60;
    {return_from_interrupt_op, clear_mask_op, set_mask_op, call_push, ret_pop} = '0;
    {reset_sp_op, alu_carry7, alu_carry3, alu_cbit, set_f, clr_f, en_in} = '0;
    {alu_op, alu_result, acc, index_reg, load_value} = '0;
    void'($urandom(32'h3ec4));
    reset_run(12);
    alu(FIS_OP_ADD);
    alu(FIS_OP_INCDEC);
    alu(FIS_OP_LOAD);
    alu(FIS_OP_ADD);
    move();
    {clk_en, fetch_step} = 2'b01;
    repeat (3) tick();
    compare("freeze", pc, instruction_address_counter);
    {clk_en, fetch_step} = 2'b10;
    enter(VEC_TRAP, 1'b1);
    leave();
    for (int t = 0; t < 8; t++)
    begin
      move();
      set_f = t < 6 ? 6'(1 << t) : 6'($urandom);
      en_in = t < 6 ? 6'h3F : 6'($urandom);
      pend = set_f & en_in;
      tick();
      set_f = '0;
      instr_done = 1'b1;
      tick();
      instr_done = 1'b0;
      repeat (6) tick();
      clear_mask_op = t[0];
      wait_op = !t[0];
      tick();
      {clear_mask_op, wait_op, m} = '0;
      if (pend != 6'h0)
      begin
        lo = 0;
        while (!pend[lo])
          lo++;
        enter(VEC_DECODER - 16'(2 * lo), 1'b0);
        clr_f = '1;
        tick();
        clr_f = '0;
        leave();
      end
      else
      begin
        {instr_done, clr_f} = 7'h7F;
        tick();
        {instr_done, clr_f} = '0;
      end
      set_mask_op = 1'b1;
      tick();
      {set_mask_op, m} = 2'b01;
    end
    reset_run(3);
    enter(VEC_TRAP, 1'b1);
    leave();
    repeat (4) tick();
    stop_test();
  end
endmodule : fis_seq_tb
`default_nettype wire
